// ---- bench/cc_far_port.sv ----
/*
  Behavioural model of the port at the far end of the cable.
  Assumes the cable carries one CC wire, seen on pin one of the block.
*/
module cc_far_port (
  input wire logic [1:0] mode,
  output cc_pkg::sense_t sense
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------------
  // Terminations
  // ---------------------------------------------------------------------
  // Mode 1 is a sink, mode 2 a source with VBUS, and 0 means no partner.
  // With no partner nothing pulls the wire, so the comparators read low.
  always_comb begin
    sense = '0;
    sense.cc_rd = (mode == 2'h1) ? 2'h1 : 2'h0;
    sense.cc_rp = (mode == 2'h2) ? 2'h1 : 2'h0;
    sense.vbus = (mode == 2'h2);
  end
endmodule : cc_far_port

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the connection detection state machine.
  Assumes short debounce, toggle and try counts set at the instance.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEB = 8;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  cc_pkg::cfg_t cfg_in = '0;
  cc_pkg::sense_t sense_in;
  logic [1:0] vrd_level = 2'h2;
  logic [1:0] far_mode = 2'h0;
  logic [1:0] cc_term;
  logic [1:0] rp_adv;
  logic [1:0] snk_current;
  logic vbus_en;
  logic vconn_en;
  logic attached;
  cc_pkg::cc_state_t state;
  int n_fail = 0;
  int check_count = 0;
  int n;
  always #2 mclk = ~mclk;
  cc_far_port u_cc_far_port (.mode(far_mode), .sense(sense_in));
  cc_attach_detach_fsm #(.DEBOUNCE_CYC(DEB), .TOGGLE_CYC(8),
    .TRY_CYC(16), .RP_LEVEL(2'h2)) u_cc_attach_detach_fsm (
    .mclk(mclk),
    .resetn(resetn),
    .cfg_in(cfg_in),
    .sense_in(sense_in),
    .vrd_level(vrd_level),
    .cc_term(cc_term),
    .rp_adv(rp_adv),
    .snk_current(snk_current),
    .vbus_en(vbus_en),
    .vconn_en(vconn_en),
    .attached(attached),
    .state(state)
  );
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic go(input cc_pkg::cc_state_t st, output int k);
    k = 0;
    while (state !== st && k < 60) begin
      @(posedge mclk);
      #1;
      k++;
    end
    check(state, st);
  endtask : go
  task automatic boot(input logic [1:0] pt, input logic [1:0] pf,
                      input logic sw);
    @(posedge mclk);
    #1;
    resetn = 1'b0;
    far_mode = 2'h0;
    cfg_in = '{port_type: pt, pref: pf, skip_wait: sw};
    repeat (10) @(posedge mclk);
    #1;
    check({cc_term, vbus_en, vconn_en}, 4'h0);
    resetn = 1'b1;
    // The first edge after release enters the home state of the strap.
    @(posedge mclk);
    #1;
    if (pt == cc_pkg::PORT_SRC) begin
      check(state, cc_pkg::ST_UNATT_SRC);
      check({2'h0, cc_term}, {2'h0, cc_pkg::TERM_RP});
    end else begin
      check(state, cc_pkg::ST_UNATT_SNK);
      check({2'h0, cc_term}, {2'h0, cc_pkg::TERM_RD});
    end
  endtask : boot
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  // A one-cycle dropout of the pull-down must restart the debounce count.
  task automatic src_only();
    boot(cc_pkg::PORT_SRC, cc_pkg::PREF_NONE, 1'b0);
    go(cc_pkg::ST_UNATT_SRC, n);
    far_mode = 2'h1;
    go(cc_pkg::ST_WAIT_SRC, n);
    repeat (DEB - 3) @(posedge mclk);
    #1 far_mode = 2'h0;
    @(posedge mclk);
    #1 far_mode = 2'h1;
    go(cc_pkg::ST_ATT_SRC, n);
    check({3'h0, n >= DEB}, 4'h1);
    check({2'h0, vbus_en, vconn_en}, 4'h3);
    check({rp_adv, cc_term}, {2'h2, cc_pkg::TERM_RP});
    far_mode = 2'h0;
    go(cc_pkg::ST_UNATT_SRC, n);
    check({3'h0, vbus_en}, 4'h0);
  endtask : src_only
  task automatic snk_only();
    boot(cc_pkg::PORT_SNK, cc_pkg::PREF_NONE, 1'b0);
    go(cc_pkg::ST_UNATT_SNK, n);
    check({2'h0, cc_term}, {2'h0, cc_pkg::TERM_RD});
    far_mode = 2'h2;
    go(cc_pkg::ST_ATT_SNK, n);
    check({3'h0, attached}, 4'h1);
    repeat (4) @(posedge mclk);
    #1;
    check({2'h0, snk_current}, 4'h2);
    vrd_level = 2'h3;
    repeat (4) @(posedge mclk);
    #1;
    check({2'h0, snk_current}, 4'h3);
    far_mode = 2'h0;
    go(cc_pkg::ST_UNATT_SNK, n);
    check({3'h0, attached}, 4'h0);
  endtask : snk_only
  // Two synchroniser edges plus the decision edge; a wait adds one more.
  task automatic snk_skip();
    boot(cc_pkg::PORT_SNK, cc_pkg::PREF_NONE, 1'b1);
    far_mode = 2'h2;
    go(cc_pkg::ST_ATT_SNK, n);
    check({3'h0, n == 3}, 4'h1);
  endtask : snk_skip
  task automatic drp_plain();
    boot(cc_pkg::PORT_DRP, cc_pkg::PREF_NONE, 1'b0);
    go(cc_pkg::ST_UNATT_SNK, n);
    go(cc_pkg::ST_UNATT_SRC, n);
    far_mode = 2'h2;
    go(cc_pkg::ST_WAIT_SNK, n);
    go(cc_pkg::ST_ATT_SNK, n);
    check({3'h0, n >= DEB}, 4'h1);
    far_mode = 2'h0;
    go(cc_pkg::ST_UNATT_SNK, n);
    go(cc_pkg::ST_UNATT_SRC, n);
    far_mode = 2'h1;
    go(cc_pkg::ST_WAIT_SRC, n);
    go(cc_pkg::ST_ATT_SRC, n);
    far_mode = 2'h0;
    go(cc_pkg::ST_UNATT_SNK, n);
    check({vbus_en, vconn_en, cc_term}, {2'h0, cc_pkg::TERM_RD});
  endtask : drp_plain
  task automatic drp_try();
    boot(cc_pkg::PORT_DRP, cc_pkg::PREF_SRC, 1'b0);
    far_mode = 2'h2;
    go(cc_pkg::ST_TRY_SRC, n);
    check({2'h0, cc_term}, {2'h0, cc_pkg::TERM_RP});
    far_mode = 2'h1;
    go(cc_pkg::ST_ATT_SRC, n);
    check({2'h0, vbus_en, vconn_en}, 4'h3);
    boot(cc_pkg::PORT_DRP, cc_pkg::PREF_SNK, 1'b0);
    far_mode = 2'h1;
    go(cc_pkg::ST_TRY_SNK, n);
    check({2'h0, cc_term}, {2'h0, cc_pkg::TERM_RD});
    far_mode = 2'h2;
    go(cc_pkg::ST_ATT_SNK, n);
  endtask : drp_try
  // ---------------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    src_only();
    snk_only();
    snk_skip();
    drp_plain();
    drp_try();
    test_done();
  end
  initial begin
    #50us;
    n_fail++;
    test_done();
  end
endmodule : tb_top

// ---- src/cc_attach_detach_fsm.sv ----
/*
  Connection detection state machine for a reversible connector port.
  Assumes CC comparator and VBUS level inputs arrive asynchronously from
  the analog front end; configuration straps are steady during reset.
*/
module cc_attach_detach_fsm #(
  parameter int unsigned DEBOUNCE_CYC = cc_pkg::DEBOUNCE_CYC,
  parameter int unsigned TOGGLE_CYC = cc_pkg::TOGGLE_CYC,
  parameter int unsigned TRY_CYC = cc_pkg::TRY_CYC,
  parameter logic [1:0] RP_LEVEL = 2'h1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire cc_pkg::cfg_t cfg_in,
  input wire cc_pkg::sense_t sense_in,
  input wire logic [1:0] vrd_level,
  output logic [1:0] cc_term,
  output logic [1:0] rp_adv,
  output logic [1:0] snk_current,
  output logic vbus_en,
  output logic vconn_en,
  output logic attached,
  output cc_pkg::cc_state_t state
);

  // ---------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------
  // The counters are 24 bits wide, so longer intervals cannot be served.
  if (DEBOUNCE_CYC < 2 || DEBOUNCE_CYC > 32'h00FFFFFF ||
      TOGGLE_CYC < 2 || TOGGLE_CYC > 32'h00FFFFFF ||
      TRY_CYC < 2 || TRY_CYC > 32'h00FFFFFF) begin : g_bad_cycles
    $error("cycle count parameter out of range");
  end

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    cc_pkg::sense_t s1;
    cc_pkg::sense_t s2;
    logic [1:0] vrd1;
    logic [1:0] vrd2;
    logic cfg_done;
    cc_pkg::cfg_t cfg;
    cc_pkg::cc_state_t st;
    logic [23:0] cnt;
    logic [1:0] cc_last;
    logic [23:0] tcnt;
    logic [1:0] term;
    logic [1:0] rp;
    logic [1:0] cur;
    logic vbus_on;
    logic vconn_on;
    logic att;
  } regs_t;

  regs_t r_ff;
  regs_t nxt_r;

  function automatic logic any2(input logic [1:0] v);
    return |v;
  endfunction : any2

  // Initial state for the port type; idle dual-role ports start as sink.
  function automatic cc_pkg::cc_state_t home(input logic [1:0] t);
    return (t == cc_pkg::PORT_SRC) ? cc_pkg::ST_UNATT_SRC :
                                     cc_pkg::ST_UNATT_SNK;
  endfunction : home

  cc_pkg::cfg_t cfg_ff;
  logic rd_seen;
  logic rp_seen;
  logic vb;
  logic is_drp;
  logic deb_done;
  logic cc_chg;

  always_comb begin
    nxt_r = r_ff;
    rd_seen = any2(r_ff.s2.cc_rd);
    rp_seen = any2(r_ff.s2.cc_rp);
    vb = r_ff.s2.vbus;
    is_drp = r_ff.cfg.port_type == cc_pkg::PORT_DRP;
    cc_chg = r_ff.term == cc_pkg::TERM_RP ?
             (r_ff.s2.cc_rd != r_ff.cc_last) :
             (r_ff.s2.cc_rp != r_ff.cc_last);
    deb_done = r_ff.cnt >= 24'(DEBOUNCE_CYC - 1);
    nxt_r.s1 = sense_in;
    nxt_r.s2 = r_ff.s1;
    nxt_r.vrd1 = vrd_level;
    nxt_r.vrd2 = r_ff.vrd1;
    nxt_r.cc_last = (r_ff.term == cc_pkg::TERM_RP) ?
                    r_ff.s2.cc_rd : r_ff.s2.cc_rp;
    // Debounce restarts on any CC change. [RQ23]
    if (cc_chg) begin
      nxt_r.cnt = '0;
    end else if (!deb_done) begin
      nxt_r.cnt = r_ff.cnt + 24'h000001;
    end
    nxt_r.tcnt = r_ff.tcnt + 24'h000001;
    if (!r_ff.cfg_done) begin
      // Straps were caught while in reset; the first edge enters home.
      nxt_r.cfg_done = 1'b1;
      nxt_r.cfg = cfg_ff;
      nxt_r.st = home(cfg_ff.port_type);
      nxt_r.tcnt = '0;
    end else begin
      case (r_ff.st)
        cc_pkg::ST_UNATT_SRC: begin
          if (rd_seen) begin
            nxt_r.st = cc_pkg::ST_WAIT_SRC; // [RQ1] [RQ15]
            nxt_r.cnt = '0;
          end else if (is_drp &&
                       r_ff.tcnt >= 24'(TOGGLE_CYC - 1)) begin
            nxt_r.st = cc_pkg::ST_UNATT_SNK; // [RQ14]
            nxt_r.tcnt = '0;
          end
        end
        cc_pkg::ST_WAIT_SRC: begin
          if (!rd_seen) begin
            nxt_r.st = home(r_ff.cfg.port_type);
            nxt_r.tcnt = '0;
          end else if (deb_done && !cc_chg) begin
            if (is_drp && r_ff.cfg.pref == cc_pkg::PREF_SNK) begin
              nxt_r.st = cc_pkg::ST_TRY_SNK; // [RQ20]
            end else begin
              nxt_r.st = cc_pkg::ST_ATT_SRC; // [RQ2]
            end
            nxt_r.tcnt = '0;
          end
        end
        cc_pkg::ST_ATT_SRC: begin
          if (!rd_seen) begin
            // Dual-role ports fall back to sink and toggle again.
            nxt_r.st = is_drp ? cc_pkg::ST_UNATT_SNK : // [RQ11] [RQ19]
                       cc_pkg::ST_UNATT_SRC; // [RQ10]
            nxt_r.tcnt = '0;
          end
        end
        cc_pkg::ST_UNATT_SNK: begin
          if (r_ff.cfg.port_type == cc_pkg::PORT_SNK &&
              r_ff.cfg.skip_wait && vb) begin
            nxt_r.st = cc_pkg::ST_ATT_SNK; // [RQ4]
          end else if (rp_seen) begin
            nxt_r.st = cc_pkg::ST_WAIT_SNK; // [RQ6]
            nxt_r.cnt = '0;
          end else if (is_drp &&
                       r_ff.tcnt >= 24'(TOGGLE_CYC - 1)) begin
            nxt_r.st = cc_pkg::ST_UNATT_SRC; // [RQ14]
            nxt_r.tcnt = '0;
          end
        end
        cc_pkg::ST_WAIT_SNK: begin
          if (!rp_seen && !vb) begin
            nxt_r.st = is_drp ? cc_pkg::ST_UNATT_SRC :
                       cc_pkg::ST_UNATT_SNK;
            nxt_r.tcnt = '0;
          end else if (!is_drp && vb) begin
            nxt_r.st = cc_pkg::ST_ATT_SNK; // [RQ5]
          end else if (deb_done && vb) begin
            if (r_ff.cfg.pref == cc_pkg::PREF_SRC) begin
              nxt_r.st = cc_pkg::ST_TRY_SRC; // [RQ16]
              nxt_r.tcnt = '0;
            end else begin
              nxt_r.st = cc_pkg::ST_ATT_SNK; // [RQ7]
            end
          end
        end
        cc_pkg::ST_ATT_SNK: begin
          if (!vb) begin
            nxt_r.st = cc_pkg::ST_UNATT_SNK; // [RQ12] [RQ13]
            nxt_r.tcnt = '0;
          end
        end
        cc_pkg::ST_TRY_SRC: begin
          // Bounded wait so a stubborn partner cannot hang the port.
          if (rd_seen) begin
            nxt_r.st = cc_pkg::ST_ATT_SRC; // [RQ18]
          end else if (r_ff.tcnt >= 24'(TRY_CYC - 1)) begin
            nxt_r.st = cc_pkg::ST_UNATT_SNK;
            nxt_r.tcnt = '0;
          end
        end
        cc_pkg::ST_TRY_SNK: begin
          if (vb) begin
            nxt_r.st = cc_pkg::ST_ATT_SNK; // [RQ22]
          end else if (r_ff.tcnt >= 24'(TRY_CYC - 1)) begin
            nxt_r.st = cc_pkg::ST_UNATT_SRC;
            nxt_r.tcnt = '0;
          end
        end
        default: begin
          nxt_r.st = home(r_ff.cfg.port_type);
        end
      endcase
    end
    // Outputs follow the next state so they register with it.
    case (nxt_r.st)
      cc_pkg::ST_UNATT_SRC,
      cc_pkg::ST_WAIT_SRC,
      cc_pkg::ST_ATT_SRC,
      cc_pkg::ST_TRY_SRC: nxt_r.term = cc_pkg::TERM_RP; // [RQ17]
      default: nxt_r.term = cc_pkg::TERM_RD; // [RQ19] [RQ21]
    endcase
    nxt_r.vbus_on = nxt_r.st == cc_pkg::ST_ATT_SRC; // [RQ3] [RQ18]
    nxt_r.vconn_on = nxt_r.st == cc_pkg::ST_ATT_SRC; // [RQ3]
    nxt_r.att = nxt_r.st == cc_pkg::ST_ATT_SRC ||
                nxt_r.st == cc_pkg::ST_ATT_SNK;
    nxt_r.rp = (nxt_r.st == cc_pkg::ST_ATT_SRC) ? RP_LEVEL : 2'h0; // [RQ8]
    nxt_r.cur = (nxt_r.st == cc_pkg::ST_ATT_SNK) ? r_ff.vrd2 : 2'h0; // [RQ9]
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_ff <= '0;
      r_ff.st <= cc_pkg::ST_UNATT_SNK;
      r_ff.term <= cc_pkg::TERM_OPEN;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Straps are caught on clocks seen while reset is held. [RQ24]
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_ff <= cfg_in;
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  // Attach steps are written as sequences so each arrow names one hop.
  sequence s_src_entry;
    r_ff.st != cc_pkg::ST_ATT_SRC ##1 r_ff.st == cc_pkg::ST_ATT_SRC;
  endsequence : s_src_entry

  sequence s_wait_src_exit;
    r_ff.st == cc_pkg::ST_WAIT_SRC ##1 r_ff.st == cc_pkg::ST_ATT_SRC;
  endsequence : s_wait_src_exit

  sequence s_wait_snk_exit;
    r_ff.st == cc_pkg::ST_WAIT_SNK && is_drp ##1
    r_ff.st == cc_pkg::ST_ATT_SNK;
  endsequence : s_wait_snk_exit

  sequence s_try_src_hit;
    r_ff.st == cc_pkg::ST_TRY_SRC && rd_seen;
  endsequence : s_try_src_hit

  property p_src_via_wait;
    @(posedge mclk) disable iff (!resetn)
      s_src_entry |-> $past(r_ff.st) == cc_pkg::ST_WAIT_SRC ||
                      $past(r_ff.st) == cc_pkg::ST_TRY_SRC;
  endproperty : p_src_via_wait
  a_src_via_wait: assert property (p_src_via_wait) // [RQ1]
    else $error("source attach did not pass a wait state");

  property p_src_debounce;
    @(posedge mclk) disable iff (!resetn)
      s_wait_src_exit |-> $past(rd_seen) &&
                          $past(r_ff.cnt) >= 24'(DEBOUNCE_CYC - 1);
  endproperty : p_src_debounce
  a_src_debounce: assert property (p_src_debounce) // [RQ2]
    else $error("source attached before the debounce ran out");

  property p_src_power;
    @(posedge mclk) disable iff (!resetn)
      s_src_entry |-> r_ff.vbus_on && r_ff.vconn_on;
  endproperty : p_src_power
  a_src_power: assert property (p_src_power) // [RQ3]
    else $error("attached source without both supplies on");

  property p_rp_adv;
    @(posedge mclk) disable iff (!resetn)
      r_ff.st == cc_pkg::ST_ATT_SRC |-> r_ff.rp == RP_LEVEL;
  endproperty : p_rp_adv
  a_rp_adv: assert property (p_rp_adv) // [RQ8]
    else $error("current advertisement wrong while attached source");

  property p_src_detach_solo;
    @(posedge mclk) disable iff (!resetn)
      r_ff.st == cc_pkg::ST_ATT_SRC && !rd_seen && !is_drp |=>
        r_ff.st == cc_pkg::ST_UNATT_SRC;
  endproperty : p_src_detach_solo
  a_src_detach_solo: assert property (p_src_detach_solo) // [RQ10]
    else $error("source-only detach did not return home");

  property p_src_detach_drp;
    @(posedge mclk) disable iff (!resetn)
      r_ff.st == cc_pkg::ST_ATT_SRC && !rd_seen && is_drp |=>
        r_ff.st == cc_pkg::ST_UNATT_SNK && !r_ff.vbus_on &&
        !r_ff.vconn_on && r_ff.term == cc_pkg::TERM_RD;
  endproperty : p_src_detach_drp
  a_src_detach_drp: assert property (p_src_detach_drp) // [RQ11] [RQ19]
    else $error("dual-role source detach handled wrongly");

  property p_snk_detach;
    @(posedge mclk) disable iff (!resetn)
      r_ff.st == cc_pkg::ST_ATT_SNK && !vb |=>
        r_ff.st == cc_pkg::ST_UNATT_SNK && !r_ff.att;
  endproperty : p_snk_detach
  a_snk_detach: assert property (p_snk_detach) // [RQ12] [RQ13]
    else $error("sink did not detach on supply loss");

  property p_snk_debounce;
    @(posedge mclk) disable iff (!resetn)
      s_wait_snk_exit |-> $past(vb) &&
                          $past(r_ff.cnt) >= 24'(DEBOUNCE_CYC - 1);
  endproperty : p_snk_debounce
  a_snk_debounce: assert property (p_snk_debounce) // [RQ7]
    else $error("dual-role sink attached before the debounce ran out");

  property p_snk_current;
    @(posedge mclk) disable iff (!resetn)
      r_ff.st == cc_pkg::ST_ATT_SNK ##1 r_ff.st == cc_pkg::ST_ATT_SNK |->
        r_ff.cur == $past(r_ff.vrd2);
  endproperty : p_snk_current
  a_snk_current: assert property (p_snk_current) // [RQ9]
    else $error("sink current does not follow the sensed level");

  property p_try_src;
    @(posedge mclk) disable iff (!resetn)
      s_try_src_hit |=> r_ff.st == cc_pkg::ST_ATT_SRC &&
                        r_ff.vbus_on && r_ff.vconn_on;
  endproperty : p_try_src
  a_try_src: assert property (p_try_src) // [RQ18]
    else $error("try-source did not attach on a pull-down");

  property p_try_snk;
    @(posedge mclk) disable iff (!resetn)
      r_ff.st == cc_pkg::ST_TRY_SNK && vb |=>
        r_ff.st == cc_pkg::ST_ATT_SNK;
  endproperty : p_try_snk
  a_try_snk: assert property (p_try_snk) // [RQ22]
    else $error("try-sink did not attach on supply");

  property p_toggle;
    @(posedge mclk) disable iff (!resetn)
      r_ff.st == cc_pkg::ST_UNATT_SRC && is_drp && !rd_seen &&
      r_ff.tcnt >= 24'(TOGGLE_CYC - 1) |=>
        r_ff.st == cc_pkg::ST_UNATT_SNK && r_ff.term == cc_pkg::TERM_RD;
  endproperty : p_toggle
  a_toggle: assert property (p_toggle) // [RQ14]
    else $error("idle dual-role port did not toggle");

  property p_restart;
    @(posedge mclk) disable iff (!resetn)
      cc_chg |=> r_ff.cnt == 24'h000000;
  endproperty : p_restart
  a_restart: assert property (p_restart) // [RQ23]
    else $error("debounce count not restarted on a change");

  assign cc_term = r_ff.term;
  assign rp_adv = r_ff.rp;
  assign snk_current = r_ff.cur;
  assign vbus_en = r_ff.vbus_on;
  assign vconn_en = r_ff.vconn_on;
  assign attached = r_ff.att;
  assign state = r_ff.st;

endmodule : cc_attach_detach_fsm

// ---- src/cc_pkg.sv ----
/*
  Constants, types and state encoding for the connection detection
  state machine. Assumes one 250 MHz clock and comparator levels from the
  analog front end.
*/
// Summary of operation
// [RQ1] Source-only attaches via attach-wait source state
// [RQ2] Pull-down must hold debounce before source attach
// [RQ3] Attached source switches VBUS and VCONN on
// [RQ4] Simple USB 2.0 sink may skip wait
// [RQ5] Sink-only attaches when VBUS is present
// [RQ6] Dual-role unattached sink sees pull-up: wait
// [RQ7] Dual-role sink attaches after debounce plus VBUS
// [RQ8] Attached source sets Rp current advertisement
// [RQ9] Attached sink reports sensed vRd current level
// [RQ10] Source-only detach returns to unattached source
// [RQ11] Dual-role source detach goes to unattached sink
// [RQ12] Sink-only VBUS loss returns to unattached sink
// [RQ13] Dual-role sink VBUS loss resumes toggling
// [RQ14] Dual-role idle port toggles source and sink
// [RQ15] Dual-role unattached source sees pull-down: wait
// [RQ16] Source-preferring port tries source after debounce
// [RQ17] Try-source presents pull-up and waits
// [RQ18] Try-source sees pull-down: attach as source
// [RQ19] Source detach drops power, presents pull-down; source-only ports return to Unattached source with pull-up
// [RQ20] Sink-preferring port tries sink after debounce
// [RQ21] Try-sink presents pull-down and waits
// [RQ22] Try-sink sees VBUS: attach as sink
// [RQ23] Debounce counter restarts on any CC change
// [RQ24] Port type and preference sampled during reset
package cc_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned DEBOUNCE_US = 100;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned TOGGLE_US = 50;
  localparam int unsigned TOGGLE_CYC = TOGGLE_US * CLK_MHZ;
  localparam int unsigned TRY_US = 150;
  localparam int unsigned TRY_CYC = TRY_US * CLK_MHZ;

  // ---------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------
  localparam logic [1:0] PORT_SRC = 2'h0;
  localparam logic [1:0] PORT_SNK = 2'h1;
  localparam logic [1:0] PORT_DRP = 2'h2;
  localparam logic [1:0] PREF_NONE = 2'h0;
  localparam logic [1:0] PREF_SRC = 2'h1;
  localparam logic [1:0] PREF_SNK = 2'h2;
  localparam logic [1:0] TERM_OPEN = 2'h0;
  localparam logic [1:0] TERM_RP = 2'h1;
  localparam logic [1:0] TERM_RD = 2'h2;

  typedef enum logic [3:0] {
    ST_UNATT_SRC,
    ST_WAIT_SRC,
    ST_ATT_SRC,
    ST_UNATT_SNK,
    ST_WAIT_SNK,
    ST_ATT_SNK,
    ST_TRY_SRC,
    ST_TRY_SNK
  } cc_state_t;

  typedef struct packed {
    logic [1:0] port_type;
    logic [1:0] pref;
    logic skip_wait;
  } cfg_t;

  typedef struct packed {
    logic [1:0] cc_rd;
    logic [1:0] cc_rp;
    logic vbus;
  } sense_t;

endpackage : cc_pkg
